// >>> hdl/csr_page_pkg.sv
`default_nettype none

package csr_page_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] CONTROL_OFS   = 6'h09;
  localparam logic [ADDR_W-1:0] ERROR_OFS     = 6'h0A;
  localparam logic [ADDR_W-1:0] COLLISION_OFS = 6'h0B;
  localparam logic [ADDR_W-1:0] TIMER_OFS     = 6'h0C;
  localparam logic [ADDR_W-1:0] CRC_LOW_OFS   = 6'h0D;

  // ----------------------------------------------------------------
  // Control field positions
  // ----------------------------------------------------------------
  localparam int CTL_STANDBY_BIT = 5;
  localparam int CTL_SLEEP_BIT   = 4;
  localparam int CTL_CIPHER_BIT  = 3;
  localparam int CTL_HALT_BIT    = 2;
  localparam int CTL_LAUNCH_BIT  = 1;
  localparam int CTL_FLUSH_BIT   = 0;

  // ----------------------------------------------------------------
  // Error field positions
  // ----------------------------------------------------------------
  localparam int ERR_KEY_BIT      = 6;
  localparam int ERR_RIGHTS_BIT   = 5;
  localparam int ERR_OVERFLOW_BIT = 4;
  localparam int ERR_CHECKSUM_BIT = 3;
  localparam int ERR_FRAME_BIT    = 2;
  localparam int ERR_PARITY_BIT   = 1;
  localparam int ERR_COLL_BIT     = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] CONTROL_RESET   = 8'h00;
  localparam logic [DATA_W-1:0] ERROR_RESET     = 8'h40;
  localparam logic [DATA_W-1:0] COLLISION_RESET = 8'h00;
  localparam logic [DATA_W-1:0] ZERO_BYTE       = 8'h00;
  localparam logic [3:0]        RX_FLAGS_CLEAR  = 4'h0;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } host_req_s;

  typedef struct packed {
    logic key_cmd_start;
    logic key_format_bad;
    logic nvm_cmd_start;
    logic nvm_rights_bad;
    logic auth2_success;
  } cmd_event_s;

  typedef struct packed {
    logic              receive_prepare_state;
    logic              rx_checksum_check_enable;
    logic              checksum_mismatch;
    logic              frame_start_bad;
    logic              parity_bad;
    logic              collision;
    logic [DATA_W-1:0] collision_bit_index;
  } rx_event_s;

  typedef struct packed {
    logic host_write;
    logic internal_write;
    logic full;
  } queue_event_s;

endpackage

`default_nettype wire

// >>> hdl/control_status_page.sv
// Contract
// - Control bit 5 written 1 enters idle: blocks off, clock keeps running.
// - Control bit 4 written 1 enters deep sleep: blocks and clock off.
// - Control bit 3 set encrypts card traffic; clear passes plain data.
// - Cipher-active set only by second authentication success, not host.
// - Control bit 2 written 1 halts the timer immediately.
// - Control bit 1 written 1 starts the timer immediately.
// - Control bit 0 written 1 flushes queue pointers, count, overflow.
// - Timer halt, timer launch and flush bits act on write, read zero.
// - Error bit 6 sets on bad key encoding, clears at key-load start.
// - Error bit 5 sets on memory rights breach, clears at memory command.
// - Error bit 4 sets when host or engine writes a full queue.
// - Error bit 3 sets on checksum mismatch while receive check enabled.
// - Error bit 2 sets on a wrong start-of-frame.
// - Error bit 1 sets on a parity failure.
// - Error bit 0 sets on a detected bit collision.
// - Error bits 3 to 0 clear in the receive-prepare state.
// - After reset error flags read only the key-format bit set.
// - Collision position gives first collision index; 0 is start bit.
// - Timer readback register returns the current timer count.
// - Checksum low byte readable; host trusts it only while done is set.
// - Checksum-done reads 1 when finished, 0 while computing.
`timescale 1ns/1ps
`default_nettype none

module control_status_page
  import csr_page_pkg::*;
(
  // Clock and reset
  input  wire logic                      MCLK,
  input  wire logic                      RST,
  // Host parallel port
  input  wire csr_page_pkg::host_req_s   HOST_REQ,
  output var  logic [csr_page_pkg::DATA_W-1:0] HOST_RDATA,
  output var  logic                      HOST_RVALID,
  // Command, receiver and queue events
  input  wire csr_page_pkg::cmd_event_s   CMD_EVENT,
  input  wire csr_page_pkg::rx_event_s    RX_EVENT,
  input  wire csr_page_pkg::queue_event_s QUEUE_EVENT,
  // Readback sources
  input  wire logic [csr_page_pkg::DATA_W-1:0] TIMER_COUNT,
  input  wire logic [csr_page_pkg::DATA_W-1:0] CHECKSUM_LOW_BYTE,
  input  wire logic                      CHECKSUM_DONE,
  // Power and unit controls, checksum-done status
  output var  logic                      STANDBY_MODE,
  output var  logic                      DEEP_SLEEP_BIT,
  output var  logic                      CIPHER_ACTIVE,
  output var  logic                      TIMER_HALT_STROBE,
  output var  logic                      TIMER_LAUNCH_STROBE,
  output var  logic                      QUEUE_CLEAR_STROBE,
  output var  logic                      CHECKSUM_DONE_FLAG
);

  import csr_page_pkg::*;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic              ctl_write;
  logic              flush_req;
  logic              halt_req;
  logic              launch_req;
  logic [DATA_W-1:0] error_flags;
  logic [DATA_W-1:0] next_error_flags;
  logic [DATA_W-1:0] collision_position;
  logic              first_collision;

  assign ctl_write = HOST_REQ.wr && (HOST_REQ.addr == CONTROL_OFS);
  assign flush_req = ctl_write && HOST_REQ.wdata[CTL_FLUSH_BIT];
  assign halt_req   = ctl_write && HOST_REQ.wdata[CTL_HALT_BIT];
  assign launch_req = ctl_write && HOST_REQ.wdata[CTL_LAUNCH_BIT];

  function automatic logic [DATA_W-1:0] read_byte(
    input logic [ADDR_W-1:0] addr
  );
    logic [DATA_W-1:0] val;
    val = ZERO_BYTE;
    unique case (addr)
      CONTROL_OFS: begin
        val[CTL_STANDBY_BIT] = STANDBY_MODE;
        val[CTL_SLEEP_BIT]   = DEEP_SLEEP_BIT;
        val[CTL_CIPHER_BIT]  = CIPHER_ACTIVE;
      end
      ERROR_OFS:     val = error_flags;
      COLLISION_OFS: val = collision_position;
      TIMER_OFS:     val = TIMER_COUNT;
      CRC_LOW_OFS:   val = CHECKSUM_LOW_BYTE;
      default:       val = ZERO_BYTE;
    endcase
    return val;
  endfunction

  // ----------------------------------------------------------------
  // Power-saving bits
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (RST) begin
      STANDBY_MODE   <= CONTROL_RESET[CTL_STANDBY_BIT];
      DEEP_SLEEP_BIT <= CONTROL_RESET[CTL_SLEEP_BIT];
    end else if (ctl_write) begin
      STANDBY_MODE   <= HOST_REQ.wdata[CTL_STANDBY_BIT];
      DEEP_SLEEP_BIT <= HOST_REQ.wdata[CTL_SLEEP_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Cipher enable
  // ----------------------------------------------------------------
  // Host may only clear it; a clear racing a success loses
  always_ff @(posedge MCLK) begin
    if (RST) begin
      CIPHER_ACTIVE <= CONTROL_RESET[CTL_CIPHER_BIT];
    end else if (CMD_EVENT.auth2_success) begin
      CIPHER_ACTIVE <= 1'b1;
    end else if (ctl_write && !HOST_REQ.wdata[CTL_CIPHER_BIT]) begin
      CIPHER_ACTIVE <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Write-only strobes
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (RST) begin
      TIMER_HALT_STROBE   <= 1'b0;
      TIMER_LAUNCH_STROBE <= 1'b0;
      QUEUE_CLEAR_STROBE  <= 1'b0;
    end else begin
      TIMER_HALT_STROBE   <= halt_req;
      TIMER_LAUNCH_STROBE <= launch_req;
      QUEUE_CLEAR_STROBE  <= flush_req;
    end
  end

  // ----------------------------------------------------------------
  // Error flags
  // ----------------------------------------------------------------
  // Clears are applied first so that a same-cycle event wins
  always_comb begin
    next_error_flags = error_flags;
    next_error_flags[DATA_W-1] = 1'b0;
    if (CMD_EVENT.key_cmd_start) begin
      next_error_flags[ERR_KEY_BIT] = 1'b0;
    end
    if (CMD_EVENT.key_format_bad) begin
      next_error_flags[ERR_KEY_BIT] = 1'b1;
    end
    if (CMD_EVENT.nvm_cmd_start) begin
      next_error_flags[ERR_RIGHTS_BIT] = 1'b0;
    end
    if (CMD_EVENT.nvm_rights_bad) begin
      next_error_flags[ERR_RIGHTS_BIT] = 1'b1;
    end
    if (flush_req) begin
      next_error_flags[ERR_OVERFLOW_BIT] = 1'b0;
    end
    if ((QUEUE_EVENT.host_write || QUEUE_EVENT.internal_write)
        && QUEUE_EVENT.full) begin
      next_error_flags[ERR_OVERFLOW_BIT] = 1'b1;
    end
    if (RX_EVENT.receive_prepare_state) begin
      next_error_flags[ERR_CHECKSUM_BIT:ERR_COLL_BIT] = RX_FLAGS_CLEAR;
    end
    if (RX_EVENT.rx_checksum_check_enable && RX_EVENT.checksum_mismatch) begin
      next_error_flags[ERR_CHECKSUM_BIT] = 1'b1;
    end
    if (RX_EVENT.frame_start_bad) begin
      next_error_flags[ERR_FRAME_BIT] = 1'b1;
    end
    if (RX_EVENT.parity_bad) begin
      next_error_flags[ERR_PARITY_BIT] = 1'b1;
    end
    if (RX_EVENT.collision) begin
      next_error_flags[ERR_COLL_BIT] = 1'b1;
    end
  end

  // Host writes to this offset are deliberately not decoded
  always_ff @(posedge MCLK) begin
    if (RST) begin
      error_flags <= ERROR_RESET;
    end else begin
      error_flags <= next_error_flags;
    end
  end

  // ----------------------------------------------------------------
  // Collision position
  // ----------------------------------------------------------------
  assign first_collision = RX_EVENT.collision
    && (RX_EVENT.receive_prepare_state || !error_flags[ERR_COLL_BIT]);

  always_ff @(posedge MCLK) begin
    if (RST) begin
      collision_position <= COLLISION_RESET;
    end else if (first_collision) begin
      collision_position <= RX_EVENT.collision_bit_index;
    end
  end

  // ----------------------------------------------------------------
  // Checksum status
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (RST) begin
      CHECKSUM_DONE_FLAG <= 1'b0;
    end else begin
      CHECKSUM_DONE_FLAG <= CHECKSUM_DONE;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (RST) begin
      HOST_RDATA  <= ZERO_BYTE;
      HOST_RVALID <= 1'b0;
    end else begin
      HOST_RVALID <= HOST_REQ.rd;
      if (HOST_REQ.rd) begin
        HOST_RDATA <= read_byte(HOST_REQ.addr);
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  standby_write_a: assert property (@(posedge MCLK) disable iff (RST)
    ctl_write |=> STANDBY_MODE == $past(HOST_REQ.wdata[CTL_STANDBY_BIT]))
    else $error("standby bit not taken from control write");

  sleep_write_a: assert property (@(posedge MCLK) disable iff (RST)
    !ctl_write |=> $stable(DEEP_SLEEP_BIT))
    else $error("deep sleep bit changed without a control write");

  cipher_host_a: assert property (@(posedge MCLK) disable iff (RST)
    (!CIPHER_ACTIVE && !CMD_EVENT.auth2_success) |=> !CIPHER_ACTIVE)
    else $error("cipher became active without authentication");

  cipher_auth_a: assert property (@(posedge MCLK) disable iff (RST)
    CMD_EVENT.auth2_success |=> CIPHER_ACTIVE)
    else $error("cipher not active after authentication success");

  halt_strobe_a: assert property (@(posedge MCLK) disable iff (RST)
    TIMER_HALT_STROBE == $past(halt_req))
    else $error("timer halt strobe not one cycle after write");

  launch_strobe_a: assert property (@(posedge MCLK) disable iff (RST)
    launch_req |=> TIMER_LAUNCH_STROBE
    ##1 (TIMER_LAUNCH_STROBE == $past(launch_req)))
    else $error("timer launch strobe wrong");

  flush_clear_a: assert property (@(posedge MCLK) disable iff (RST)
    (flush_req && !QUEUE_EVENT.full)
    |=> QUEUE_CLEAR_STROBE && !error_flags[ERR_OVERFLOW_BIT])
    else $error("flush did not clear overflow and pulse");

  strobe_read_a: assert property (@(posedge MCLK) disable iff (RST)
    (HOST_REQ.rd && HOST_REQ.addr == CONTROL_OFS)
    |=> HOST_RVALID && HOST_RDATA[CTL_HALT_BIT:CTL_FLUSH_BIT] == 3'h0)
    else $error("write-only control bits read nonzero");

  key_fault_a: assert property (@(posedge MCLK) disable iff (RST)
    (CMD_EVENT.key_cmd_start && !CMD_EVENT.key_format_bad)
    |=> !error_flags[ERR_KEY_BIT])
    else $error("key fault not cleared at key-load start");

  rights_fault_a: assert property (@(posedge MCLK) disable iff (RST)
    CMD_EVENT.nvm_rights_bad |=> error_flags[ERR_RIGHTS_BIT])
    else $error("rights fault not set");

  overflow_set_a: assert property (@(posedge MCLK) disable iff (RST)
    (QUEUE_EVENT.internal_write && QUEUE_EVENT.full)
    |=> error_flags[ERR_OVERFLOW_BIT])
    else $error("overflow flag not set on full write");

  checksum_fault_a: assert property (@(posedge MCLK) disable iff (RST)
    (RX_EVENT.checksum_mismatch && !RX_EVENT.rx_checksum_check_enable
     && !error_flags[ERR_CHECKSUM_BIT]) |=> !error_flags[ERR_CHECKSUM_BIT])
    else $error("checksum fault set while check disabled");

  frame_fault_a: assert property (@(posedge MCLK) disable iff (RST)
    RX_EVENT.frame_start_bad |=> error_flags[ERR_FRAME_BIT])
    else $error("frame start fault not set");

  parity_fault_a: assert property (@(posedge MCLK) disable iff (RST)
    RX_EVENT.parity_bad |=> error_flags[ERR_PARITY_BIT])
    else $error("parity fault not set");

  collision_fault_a: assert property (@(posedge MCLK) disable iff (RST)
    RX_EVENT.collision |=> error_flags[ERR_COLL_BIT])
    else $error("collision fault not set");

  prepare_clear_a: assert property (@(posedge MCLK) disable iff (RST)
    (RX_EVENT.receive_prepare_state && !RX_EVENT.collision
     && !RX_EVENT.parity_bad && !RX_EVENT.frame_start_bad
     && !RX_EVENT.checksum_mismatch)
    |=> error_flags[ERR_CHECKSUM_BIT:ERR_COLL_BIT] == RX_FLAGS_CLEAR)
    else $error("receive flags not cleared in prepare");

  reset_flags_a: assert property (@(posedge MCLK)
    RST |=> error_flags == ERROR_RESET)
    else $error("error flags wrong after reset");

  collision_index_a: assert property (@(posedge MCLK) disable iff (RST)
    first_collision
    |=> collision_position == $past(RX_EVENT.collision_bit_index))
    else $error("collision position not captured");

  timer_read_a: assert property (@(posedge MCLK) disable iff (RST)
    (HOST_REQ.rd && HOST_REQ.addr == TIMER_OFS)
    |=> HOST_RDATA == $past(TIMER_COUNT))
    else $error("timer readback mismatch");

  crc_read_a: assert property (@(posedge MCLK) disable iff (RST)
    (HOST_REQ.rd && HOST_REQ.addr == CRC_LOW_OFS)
    |=> HOST_RDATA == $past(CHECKSUM_LOW_BYTE))
    else $error("checksum low byte readback mismatch");

  crc_done_a: assert property (@(posedge MCLK) disable iff (RST)
    1'b1 |=> CHECKSUM_DONE_FLAG == $past(CHECKSUM_DONE))
    else $error("checksum done flag not following source");

  ro_write_a: assert property (@(posedge MCLK) disable iff (RST)
    (HOST_REQ.wr && HOST_REQ.addr == COLLISION_OFS && !first_collision)
    |=> $stable(collision_position))
    else $error("read-only register changed by host write");

  read_valid_a: assert property (@(posedge MCLK) disable iff (RST)
    1'b1 |=> HOST_RVALID == $past(HOST_REQ.rd))
    else $error("read valid not one cycle after read request");

  host_overflow_a: assert property (@(posedge MCLK) disable iff (RST)
    (QUEUE_EVENT.host_write && QUEUE_EVENT.full)
    |=> error_flags[ERR_OVERFLOW_BIT])
    else $error("overflow flag not set on host write to full queue");

  cipher_clear_a: assert property (@(posedge MCLK) disable iff (RST)
    (ctl_write && !HOST_REQ.wdata[CTL_CIPHER_BIT] && !CMD_EVENT.auth2_success)
    |=> !CIPHER_ACTIVE)
    else $error("cipher still active after host clear");

endmodule

`default_nettype wire

// >>> test/host_port_model.sv
`timescale 1ns/1ps
`default_nettype none

module host_port_model
  import csr_page_pkg::*;
(
  // Clock
  input  wire logic                        mclk,
  // Register port
  output var  csr_page_pkg::host_req_s     host_req,
  input  wire logic [csr_page_pkg::DATA_W-1:0] host_rdata,
  input  wire logic                        host_rvalid,
  // Checksum status
  input  wire logic                        checksum_done_flag
);
  import csr_page_pkg::*;

  initial host_req = '0;

  // ----------------------------------------------------------------
  // Single-byte cycles
  // ----------------------------------------------------------------
  task automatic put(input logic w, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d);
    @(negedge mclk);
    host_req = '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge mclk);
    // Idle lines carry no stale value
    host_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask

  task automatic read(input logic [ADDR_W-1:0] a,
                      output logic [DATA_W-1:0] d, output logic ok);
    int n;
    put(1'b0, a, ZERO_BYTE);
    ok = 1'b0;
    d = '0;
    for (n = 0; n < 4 && !ok; n++) begin
      if (host_rvalid === 1'b1) begin
        ok = 1'b1;
        d = host_rdata;
      end else begin
        @(negedge mclk);
      end
    end
  endtask

  // Checksum byte only trusted once done
  task automatic read_crc(output logic [DATA_W-1:0] d, output logic ok);
    int n;
    ok = 1'b0;
    d = '0;
    for (n = 0; n < 8 && checksum_done_flag !== 1'b1; n++) begin
      @(negedge mclk);
    end
    if (checksum_done_flag === 1'b1) begin
      read(CRC_LOW_OFS, d, ok);
    end
  endtask
endmodule

`default_nettype wire

// >>> test/control_status_page_tb.sv
`timescale 1ns/1ps
`default_nettype none

module control_status_page_tb;
  import csr_page_pkg::*;

  logic                mclk;
  logic                rst;
  host_req_s           host_req;
  logic [DATA_W-1:0]   rdata;
  logic                rvalid;
  cmd_event_s          cmd;
  rx_event_s           rx;
  queue_event_s        qev;
  logic [DATA_W-1:0]   timer_count;
  logic [DATA_W-1:0]   crc_low;
  logic                crc_done;
  logic                standby;
  logic                sleep;
  logic                cipher;
  logic                halt;
  logic                launch;
  logic                clear;
  logic                done_flag;
  int                  err_total;
  int                  tests_run;

  control_status_page u_dut (
    .MCLK(mclk), .RST(rst), .HOST_REQ(host_req), .HOST_RDATA(rdata),
    .HOST_RVALID(rvalid), .CMD_EVENT(cmd), .RX_EVENT(rx),
    .QUEUE_EVENT(qev), .TIMER_COUNT(timer_count),
    .CHECKSUM_LOW_BYTE(crc_low), .CHECKSUM_DONE(crc_done),
    .STANDBY_MODE(standby), .DEEP_SLEEP_BIT(sleep),
    .CIPHER_ACTIVE(cipher), .TIMER_HALT_STROBE(halt),
    .TIMER_LAUNCH_STROBE(launch), .QUEUE_CLEAR_STROBE(clear),
    .CHECKSUM_DONE_FLAG(done_flag)
  );

  host_port_model u_host (
    .mclk(mclk), .host_req(host_req), .host_rdata(rdata),
    .host_rvalid(rvalid), .checksum_done_flag(done_flag)
  );

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task automatic end_of_test();
    $display("Checks run: %0d, mismatches: %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      err_total++;
    end
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    u_host.read(a, d, ok);
    chk({7'h00, ok}, 8'h01);
    if (ok) begin
      chk(d, exp);
    end else begin
      end_of_test();
    end
  endtask

  // Event pulses, one cycle wide
  task automatic cev(input logic [4:0] v);
    @(negedge mclk);
    cmd = cmd_event_s'(v);
    @(negedge mclk);
    cmd = '0;
  endtask

  // Flags: prepare, enable, mismatch, frame, parity, collision
  task automatic rxev(input logic [5:0] f, input logic [7:0] idx);
    @(negedge mclk);
    rx = rx_event_s'({f, idx});
    @(negedge mclk);
    rx = rx_event_s'({6'h00, ~idx});
  endtask

  // Host write, internal write, full
  task automatic qpulse(input logic [2:0] v);
    @(negedge mclk);
    qev = queue_event_s'(v);
    @(negedge mclk);
    qev = '0;
  endtask

  task automatic strobe_chk(input logic [7:0] wd, input logic [2:0] exp);
    int n;
    u_host.put(1'b1, CONTROL_OFS, wd);
    for (n = 0; n < 3 && !(halt | launch | clear); n++) begin
      @(negedge mclk);
    end
    chk({5'h00, halt, launch, clear}, {5'h00, exp});
    @(negedge mclk);
    chk({5'h00, halt, launch, clear}, 8'h00);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rd_chk(CONTROL_OFS, CONTROL_RESET);
    rd_chk(ERROR_OFS, ERROR_RESET);
    rd_chk(COLLISION_OFS, COLLISION_RESET);
    rd_chk(6'h3F, 8'h00);
  endtask

  task automatic t_strobes();
    int i;
    for (i = 0; i < 3; i++) begin
      strobe_chk(8'h01 << i, 3'b001 << i);
    end
    strobe_chk(8'h07, 3'b111);
    rd_chk(CONTROL_OFS, 8'h00);
  endtask

  task automatic t_power();
    u_host.put(1'b1, CONTROL_OFS, 8'h30);
    chk({6'h00, standby, sleep}, 8'h03);
    rd_chk(CONTROL_OFS, 8'h30);
    u_host.put(1'b1, CONTROL_OFS, 8'hC8);
    chk({5'h00, standby, sleep, cipher}, 8'h00);
    rd_chk(CONTROL_OFS, 8'h00);
  endtask

  task automatic t_cipher();
    cev(5'b00001);
    chk({7'h00, cipher}, 8'h01);
    rd_chk(CONTROL_OFS, 8'h08);
    u_host.put(1'b1, CONTROL_OFS, 8'h00);
    chk({7'h00, cipher}, 8'h00);
  endtask

  task automatic t_errors();
    cev(5'b10000);
    rd_chk(ERROR_OFS, 8'h00);
    cev(5'b01000);
    rd_chk(ERROR_OFS, 8'h40);
    cev(5'b10000);
    cev(5'b00010);
    rd_chk(ERROR_OFS, 8'h20);
    cev(5'b00100);
    qpulse(3'b101);
    rd_chk(ERROR_OFS, 8'h10);
    u_host.put(1'b1, CONTROL_OFS, 8'h01);
    rd_chk(ERROR_OFS, 8'h00);
    qpulse(3'b011);
    rd_chk(ERROR_OFS, 8'h10);
    u_host.put(1'b1, CONTROL_OFS, 8'h01);
    qpulse(3'b100);
    rxev(6'b001000, 8'h00);
    rd_chk(ERROR_OFS, 8'h00);
    rxev(6'b011000, 8'h00);
    rxev(6'b000100, 8'h00);
    rxev(6'b000010, 8'h00);
    rd_chk(ERROR_OFS, 8'h0E);
    rxev(6'b000001, 8'h05);
    rxev(6'b000001, 8'h07);
    rd_chk(ERROR_OFS, 8'h0F);
    rd_chk(COLLISION_OFS, 8'h05);
    u_host.put(1'b1, ERROR_OFS, 8'hFF);
    rd_chk(ERROR_OFS, 8'h0F);
    u_host.put(1'b1, COLLISION_OFS, 8'hAA);
    rd_chk(COLLISION_OFS, 8'h05);
    cev(5'b00010);
    rxev(6'b100000, 8'h00);
    rd_chk(ERROR_OFS, 8'h20);
    rxev(6'b000001, 8'h00);
    rd_chk(COLLISION_OFS, 8'h00);
    rd_chk(ERROR_OFS, 8'h21);
  endtask

  task automatic t_readback();
    logic [7:0] d;
    logic       ok;
    timer_count = 8'hA5;
    rd_chk(TIMER_OFS, 8'hA5);
    timer_count = 8'h5A;
    u_host.put(1'b1, TIMER_OFS, 8'h00);
    rd_chk(TIMER_OFS, 8'h5A);
    crc_low = 8'h3C;
    repeat (2) @(negedge mclk);
    chk({7'h00, done_flag}, 8'h00);
    crc_done = 1'b1;
    u_host.read_crc(d, ok);
    chk({7'h00, ok}, 8'h01);
    chk(d, 8'h3C);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    err_total = 0;
    tests_run = 0;
    rst = 1'b1;
    cmd = '0;
    rx = '0;
    qev = '0;
    timer_count = 8'h00;
    crc_low = 8'h00;
    crc_done = 1'b0;
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    t_reset();
    t_strobes();
    t_power();
    t_cipher();
    t_errors();
    t_readback();
    end_of_test();
  end
endmodule

`default_nettype wire
